// >>> rtl/setpoint_pkg.sv
// Functional notes
// - four actions: high/low acting, balanced/unbalanced
// - setpoint held within -9999 to 99999 counts
// - hysteresis held within 1 to 59999 counts
// - unbalanced band below high, above low setpoint
// - setpoint uses the display's own decimal scaling
// - on delay 0.0 to 599.9 s, zero immediate
// - off delay 0.0 to 599.9 s before off
// - auto mode follows action; manual reset forces off
// - latch modes hold on until any reset
// - latch-immediate reset turns output off at once
// - latch-delayed reset waits for trigger-off crossing
// - after power-up high-acting output starts off below setpoint
// - pending delayed reset lost across power cycle
// - display reset also resets output when enabled, display is the reset source and input shown
// - standby keeps output off until first crossing
// - open probe drives programmed burn-out state
// - backlight colour toggles on output change
// - disabled setpoint leaves output undriven
package setpoint_pkg;

  // delay resolution is one tenth of a second
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // apb byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] SP_OFF     = 8'h04;
  localparam logic [7:0] HYST_OFF   = 8'h08;
  localparam logic [7:0] ONDLY_OFF  = 8'h0C;
  localparam logic [7:0] OFFDLY_OFF = 8'h10;
  localparam logic [7:0] CMD_OFF    = 8'h14;
  localparam logic [7:0] STAT_OFF   = 8'h18;

  // field widths and positions
  localparam int unsigned CTRL_W   = 9;
  localparam int unsigned SP_W     = 18;
  localparam int unsigned HYST_W   = 16;
  localparam int unsigned DLY_W    = 13;
  localparam int unsigned STAT_W   = 6;
  localparam int unsigned CMD_RST_BIT = 0;

  // limits and reset values
  localparam logic signed [17:0] SP_MAX   = 18'sh1869F;
  localparam logic signed [17:0] SP_MIN   = 18'sh3D8F1;
  localparam logic [15:0]        HYST_MAX = 16'hEA5F;
  localparam logic [15:0]        HYST_MIN = 16'h0001;
  localparam logic [12:0]        DLY_MAX  = 13'h176F;
  localparam logic [8:0]         CTRL_RST = 9'h000;
  localparam logic [17:0]        SP_RST   = 18'h00000;
  localparam logic [15:0]        HYST_RST = 16'h0001;
  localparam logic [12:0]        DLY_RST  = 13'h0000;

  typedef enum logic [1:0] {
    high_balanced_action,
    low_balanced_action,
    high_unbalanced_action,
    low_unbalanced_action
  } action_t;

  typedef enum logic [1:0] {
    auto_reset_mode,
    latch_immediate_mode,
    latch_delayed_mode,
    spare_reset_mode
  } reset_mode_t;

  // control register layout, enable in bit 0
  typedef struct packed {
    logic        rst_with_disp;
    logic        color_en;
    logic        burnout_on;
    logic        standby_en;
    reset_mode_t rmode;
    action_t     action;
    logic        enable;
  } ctrl_t;

  // status register layout, output state in bit 0
  typedef struct packed {
    logic color;
    logic standby;
    logic pending;
    logic trig_delayed;
    logic trig_raw;
    logic out_state;
  } status_t;

endpackage

// >>> rtl/delay_filter.sv
// level follows target after delay ticks of stable disagreement
module delay_filter (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        target,
  input  wire logic        tick,
  input  wire logic [12:0] delay,
  // filtered level
  output logic             state
);

  logic [12:0] count_reg;
  logic        state_reg;

  assign state = state_reg;

  // count tenths while target differs; agreement clears the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= setpoint_pkg::DLY_RST;
      state_reg <= 1'b0;
    end else if (target == state_reg) begin
      count_reg <= setpoint_pkg::DLY_RST;
    end else if (delay == setpoint_pkg::DLY_RST) begin
      state_reg <= target;
    end else if (tick) begin
      if (count_reg + 13'h0001 >= delay) begin
        state_reg <= target;
        count_reg <= setpoint_pkg::DLY_RST;
      end else begin
        count_reg <= count_reg + 13'h0001;
      end
    end
  end

endmodule

// >>> rtl/setpoint_alarm_output.sv
module setpoint_alarm_output #(
  parameter int unsigned TICK_CYCLES = setpoint_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // measurement from meter logic
  input  wire logic [17:0] display_value,
  input  wire logic        display_valid,
  input  wire logic        display_reset,
  input  wire logic        rst_src_is_display,
  input  wire logic        input_shown,
  // pins
  input  wire logic        front_rst_btn,
  input  wire logic        user_rst_in,
  input  wire logic        probe_open,
  // output card and backlight
  output logic             out_drive,
  output logic             out_en,
  output logic             backlight_alt
);

  setpoint_pkg::ctrl_t   ctrl_reg;
  setpoint_pkg::status_t stat;
  logic [17:0] sp_reg;
  logic [15:0] hyst_reg;
  logic [12:0] on_dly_reg;
  logic [12:0] off_dly_reg;
  logic [31:0] prdata_reg;
  logic        serial_rst_reg;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [23:0] tick_cnt_reg;
  logic        tick;
  logic        trig_raw_reg;
  logic        trig_d;
  logic        trig_d_prev_reg;
  logic        seen_off_reg;
  logic        out_reg;
  logic        pending_reg;
  logic        out_drive_reg;
  logic        out_en_reg;
  logic        color_reg;
  logic        rise_d;
  logic        fall_d;
  logic        set_evt;
  logic        rst_any;
  logic        final_next;
  logic        on_cond;
  logic        wr;
  logic        probe_s;
  logic signed [19:0] v;
  logic signed [19:0] s;
  logic signed [19:0] hf;
  logic signed [19:0] hl;
  logic signed [19:0] hh;
  logic signed [19:0] on_th;
  logic signed [19:0] off_th;
  logic        bal;
  logic        high;

  // valid register offsets, shared by write strobe and error answer
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == setpoint_pkg::CTRL_OFF)  ||
              (a == setpoint_pkg::SP_OFF)    ||
              (a == setpoint_pkg::HYST_OFF)  ||
              (a == setpoint_pkg::ONDLY_OFF) ||
              (a == setpoint_pkg::OFFDLY_OFF) ||
              (a == setpoint_pkg::CMD_OFF)   ||
              (a == setpoint_pkg::STAT_OFF);
  endfunction

  // zero wait state slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign prdata  = prdata_reg;
  assign wr      = psel && penable && pwrite && reg_hit(paddr);

  // read data captured in setup so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        setpoint_pkg::CTRL_OFF:   prdata_reg <= {23'h0, ctrl_reg};
        setpoint_pkg::SP_OFF:     prdata_reg <= {{14{sp_reg[17]}}, sp_reg};
        setpoint_pkg::HYST_OFF:   prdata_reg <= {16'h0, hyst_reg};
        setpoint_pkg::ONDLY_OFF:  prdata_reg <= {19'h0, on_dly_reg};
        setpoint_pkg::OFFDLY_OFF: prdata_reg <= {19'h0, off_dly_reg};
        setpoint_pkg::STAT_OFF:   prdata_reg <= {26'h0, stat};
        default:                  prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= setpoint_pkg::CTRL_RST;
    end else if (wr && paddr == setpoint_pkg::CTRL_OFF) begin
      ctrl_reg <= pwdata[8:0];
    end
  end

  // setpoint write, clamped into the legal count range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= setpoint_pkg::SP_RST;
    end else if (wr && paddr == setpoint_pkg::SP_OFF) begin
      if ($signed(pwdata) > $signed({{14{1'b0}}, setpoint_pkg::SP_MAX})) begin
        sp_reg <= setpoint_pkg::SP_MAX;
      end else if ($signed(pwdata) < -32'sd9999) begin
        sp_reg <= setpoint_pkg::SP_MIN;
      end else begin
        sp_reg <= pwdata[17:0];
      end
    end
  end

  // hysteresis write, clamped to 1..59999
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst_reg <= setpoint_pkg::HYST_RST;
    end else if (wr && paddr == setpoint_pkg::HYST_OFF) begin
      if (pwdata > {16'h0, setpoint_pkg::HYST_MAX}) begin
        hyst_reg <= setpoint_pkg::HYST_MAX;
      end else if (pwdata[15:0] == 16'h0000 || pwdata[31:16] != 16'h0) begin
        hyst_reg <= setpoint_pkg::HYST_MIN;
      end else begin
        hyst_reg <= pwdata[15:0];
      end
    end
  end

  // delay writes in tenths, clamped to 599.9 s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_dly_reg  <= setpoint_pkg::DLY_RST;
      off_dly_reg <= setpoint_pkg::DLY_RST;
    end else if (wr) begin
      if (paddr == setpoint_pkg::ONDLY_OFF) begin
        on_dly_reg <= (pwdata > {19'h0, setpoint_pkg::DLY_MAX}) ?
                      setpoint_pkg::DLY_MAX : pwdata[12:0];
      end
      if (paddr == setpoint_pkg::OFFDLY_OFF) begin
        off_dly_reg <= (pwdata > {19'h0, setpoint_pkg::DLY_MAX}) ?
                       setpoint_pkg::DLY_MAX : pwdata[12:0];
      end
    end
  end

  // serial reset command is a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_rst_reg <= 1'b0;
    end else begin
      serial_rst_reg <= wr && paddr == setpoint_pkg::CMD_OFF &&
                        pwdata[setpoint_pkg::CMD_RST_BIT];
    end
  end

  // two-flop synchronisers for the pins, third stage for edges
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
        sync3_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= (i == 0) ? front_rst_btn :
                        (i == 1) ? user_rst_in : probe_open;
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
      end
    end
  end
  assign probe_s = sync2_reg[2];

  // all reset sources merged; momentary press acts on its edge
  assign rst_any = (sync2_reg[0] && !sync3_reg[0]) ||
                   (sync2_reg[1] && !sync3_reg[1]) ||
                   serial_rst_reg ||
                   (ctrl_reg.rst_with_disp && display_reset &&
                    rst_src_is_display && input_shown);

  // tenth-second tick; long count is a parameter for simulation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 24'h000000;
    end else if (tick) begin
      tick_cnt_reg <= 24'h000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
    end
  end
  assign tick = (tick_cnt_reg == 24'(TICK_CYCLES - 1));

  // thresholds in raw display counts; scaling matches the display
  always_comb begin
    bal  = ctrl_reg.action == setpoint_pkg::high_balanced_action ||
           ctrl_reg.action == setpoint_pkg::low_balanced_action;
    high = ctrl_reg.action == setpoint_pkg::high_balanced_action ||
           ctrl_reg.action == setpoint_pkg::high_unbalanced_action;
    v  = {{2{display_value[17]}}, display_value};
    s  = {{2{sp_reg[17]}}, sp_reg};
    hf = {4'h0, hyst_reg};
    hl = {5'h00, hyst_reg[15:1]};
    hh = hf - hl;
    if (high) begin
      on_th  = bal ? s + hh : s;
      off_th = bal ? s - hl : s - hf;
      on_cond = v >= on_th;
    end else begin
      on_th  = bal ? s - hl : s;
      off_th = bal ? s + hh : s + hf;
      on_cond = v <= on_th;
    end
  end

  // raw trigger with hysteresis, updated on each new reading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_raw_reg <= 1'b0;
    end else if (display_valid) begin
      if (on_cond) begin
        trig_raw_reg <= 1'b1;
      end else if (high ? (v <= off_th) : (v >= off_th)) begin
        trig_raw_reg <= 1'b0;
      end
    end
  end

  // on and off delays share one filter, delay picked by direction
  delay_filter u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .target  (trig_raw_reg),
    .tick    (tick),
    .delay   (trig_raw_reg ? on_dly_reg : off_dly_reg),
    .state   (trig_d)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d_prev_reg <= 1'b0;
    end else begin
      trig_d_prev_reg <= trig_d;
    end
  end
  assign rise_d = trig_d && !trig_d_prev_reg;
  assign fall_d = !trig_d && trig_d_prev_reg;

  // standby arms only after a reading on the off side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_off_reg <= 1'b0;
    end else if (display_valid && !on_cond) begin
      seen_off_reg <= 1'b1;
    end
  end
  assign set_evt = rise_d && !(ctrl_reg.standby_en && !seen_off_reg);

  // output state; turn-on beats a reset in the same cycle
  // starts off at power-up, so a high-acting output never comes up on at a low reading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
    end else if (!ctrl_reg.enable) begin
      out_reg <= 1'b0;
    end else if (set_evt) begin
      out_reg <= 1'b1;
    end else begin
      case (ctrl_reg.rmode)
        setpoint_pkg::latch_immediate_mode: begin
          if (rst_any) out_reg <= 1'b0;
        end
        setpoint_pkg::latch_delayed_mode: begin
          if ((pending_reg || rst_any) && !trig_d) begin
            out_reg <= 1'b0;
          end
        end
        default: begin
          if (fall_d || rst_any) out_reg <= 1'b0;
        end
      endcase
    end
  end

  // remembered delayed reset; cleared by reset, never kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else if (ctrl_reg.rmode == setpoint_pkg::latch_delayed_mode &&
                 rst_any && out_reg && trig_d) begin
      pending_reg <= 1'b1;
    end else if (!out_reg || !trig_d ||
                 ctrl_reg.rmode != setpoint_pkg::latch_delayed_mode) begin
      pending_reg <= 1'b0;
    end
  end

  // pin level: disabled undriven, open probe forces burn-out state
  assign final_next = !ctrl_reg.enable ? 1'b0 :
                      probe_s ? ctrl_reg.burnout_on : out_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_drive_reg <= 1'b0;
      out_en_reg    <= 1'b0;
    end else begin
      out_drive_reg <= final_next;
      out_en_reg    <= ctrl_reg.enable;
    end
  end

  // colour flips with every change of the driven level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      color_reg <= 1'b0;
    end else if (ctrl_reg.color_en && final_next != out_drive_reg) begin
      color_reg <= !color_reg;
    end
  end

  assign out_drive     = out_drive_reg;
  assign out_en        = out_en_reg;
  assign backlight_alt = color_reg;

  always_comb begin
    stat.color        = color_reg;
    stat.standby      = ctrl_reg.standby_en && !seen_off_reg;
    stat.pending      = pending_reg;
    stat.trig_delayed = trig_d;
    stat.trig_raw     = trig_raw_reg;
    stat.out_state    = out_drive_reg;
  end

  // checks beside the logic
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DISABLED_UNDRIVEN: assert property (
    !ctrl_reg.enable |=> !out_en && !out_drive)
    else $error("disabled output still driven");

  AST_BURNOUT: assert property (
    ctrl_reg.enable && probe_s |=> out_drive == $past(ctrl_reg.burnout_on))
    else $error("open probe did not force burn-out level");

  AST_LATCH_HOLD: assert property (
    ctrl_reg.enable && out_reg && !rst_any &&
    ctrl_reg.rmode == setpoint_pkg::latch_immediate_mode |=> out_reg)
    else $error("latched output dropped without reset");

  AST_IMM_RESET: assert property (
    ctrl_reg.rmode == setpoint_pkg::latch_immediate_mode &&
    rst_any && !set_evt |=> !out_reg)
    else $error("immediate reset did not clear output");

  AST_DELAYED_PEND: assert property (
    ctrl_reg.enable && out_reg && trig_d && rst_any && !set_evt &&
    ctrl_reg.rmode == setpoint_pkg::latch_delayed_mode
    |=> pending_reg && out_reg)
    else $error("delayed reset not remembered");

  AST_AUTO_FALL: assert property (
    ctrl_reg.rmode == setpoint_pkg::auto_reset_mode && fall_d
    |=> !out_reg)
    else $error("auto mode did not turn off at trigger-off");

  AST_ZERO_ON_DELAY: assert property (
    $rose(trig_raw_reg) && on_dly_reg == 13'h0000 |-> ##1 trig_d)
    else $error("zero on delay not immediate");

  AST_STANDBY_OFF: assert property (
    ctrl_reg.standby_en && !seen_off_reg && !out_reg |=> !out_reg)
    else $error("standby output turned on early");

  AST_COLOR: assert property (
    $past(ctrl_reg.color_en) && $changed(out_drive) |-> $changed(color_reg))
    else $error("colour did not follow output change");

  AST_HYST_RANGE: assert property (
    hyst_reg >= 16'h0001 && hyst_reg <= setpoint_pkg::HYST_MAX)
    else $error("hysteresis out of range");

  AST_SP_RANGE: assert property (
    $signed(sp_reg) <= setpoint_pkg::SP_MAX &&
    $signed(sp_reg) >= -18'sd9999)
    else $error("setpoint out of range");

  AST_DISP_RESET: assert property (
    ctrl_reg.rst_with_disp && display_reset && rst_src_is_display &&
    input_shown && !set_evt &&
    ctrl_reg.rmode == setpoint_pkg::latch_immediate_mode |=> !out_reg)
    else $error("display reset did not reach output");

  COV_LATCH_DELAYED: cover property (pending_reg ##[1:1000] !out_reg);
  COV_ON_DELAY: cover property ($rose(trig_raw_reg) ##[2:1000] rise_d);
  COV_BURNOUT_ON: cover property (probe_s && out_drive);

endmodule

// >>> test/output_card_model.sv
// relay card seen from the block's output pins
module output_card_model (
  // clock
  input  wire logic pclk,
  // drive from the block
  input  wire logic out_drive,
  input  wire logic out_en,
  // contact state
  output logic      relay_on
);
  timeunit 1ns;
  timeprecision 1ps;

  // undriven input is pulled down on the card, so relay drops
  always_ff @(posedge pclk) begin
    relay_on <= out_en & out_drive;
  end
endmodule

// >>> test/setpoint_alarm_output_test.sv
module setpoint_alarm_output_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [17:0] display_value;
  logic        display_valid;
  logic        display_reset;
  logic        rst_src_is_display;
  logic        input_shown;
  logic        front_rst_btn;
  logic        user_rst_in;
  logic        probe_open;
  logic        out_drive;
  logic        out_en;
  logic        backlight_alt;
  logic        relay_on;
  logic [31:0] rd;
  logic        err;
  logic        c;
  int          fail_count;
  int          tests_run;
  int          s;
  int          h;
  int          d;
  logic [7:0]  offs [5] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0C};
  logic [31:0] wv [5] = '{32'h000186A0, 32'hFFFFD8F0, 32'h0, 32'hEA60,
                          32'h1770};
  logic [31:0] ev [5] = '{32'h0001869F, 32'hFFFFD8F1, 32'h1, 32'hEA5F,
                          32'h176F};

  // short tick keeps delay scenarios to tens of cycles
  setpoint_alarm_output #(.TICK_CYCLES(10)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .display_value(display_value),
    .display_valid(display_valid), .display_reset(display_reset),
    .rst_src_is_display(rst_src_is_display), .input_shown(input_shown),
    .front_rst_btn(front_rst_btn), .user_rst_in(user_rst_in),
    .probe_open(probe_open), .out_drive(out_drive), .out_en(out_en),
    .backlight_alt(backlight_alt)
  );

  output_card_model card (
    .pclk(pclk), .out_drive(out_drive), .out_en(out_en),
    .relay_on(relay_on)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cw(int a, int m, logic [31:0] x);
    return x | 32'(m << 3) | 32'(a << 1) | 32'h1;
  endfunction

  function automatic int on_th(int a, int sp, int hy);
    case (a)
      0: return sp + (hy - hy / 2);
      1: return sp - hy / 2;
      default: return sp;
    endcase
  endfunction

  function automatic int off_th(int a, int sp, int hy);
    case (a)
      0: return sp - hy / 2;
      1: return sp + (hy - hy / 2);
      2: return sp - hy;
      default: return sp + hy;
    endcase
  endfunction

  task automatic cfg(input logic [31:0] ctl, input int sp, input int hy);
    apb(1'b1, 8'h00, ctl);
    apb(1'b1, 8'h04, 32'(sp));
    apb(1'b1, 8'h08, 32'(hy));
  endtask

  // one reading, then output checked once the pipeline settled
  task automatic meas(input int v, input logic e);
    @(posedge pclk);
    display_value <= 18'(v);
    display_valid <= 1'b1;
    @(posedge pclk);
    display_valid <= 1'b0;
    repeat (6) @(posedge pclk);
    chk1(out_drive, e);
  endtask

  task automatic press(input logic f, input logic u, input logic dr);
    @(posedge pclk);
    front_rst_btn <= f;
    user_rst_in <= u;
    display_reset <= dr;
    @(posedge pclk);
    display_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    front_rst_btn <= 1'b0;
    user_rst_in <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    final_report();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {display_value, display_valid, display_reset} = '0;
    {rst_src_is_display, input_shown, front_rst_btn} = '0;
    {user_rst_in, probe_open, fail_count, tests_run} = '0;
    void'($urandom(32'hE42C));
    do_reset();
    // reset values, unmapped offset, clamping
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, (i == 2) ? 32'h1 : 32'h0);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk1(err, 1'b1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, offs[i], wv[i]);
      apb(1'b0, offs[i], 32'h0);
      chk(rd, ev[i]);
    end
    apb(1'b1, 8'h0C, 32'h0);
    // every action with random setpoint and band
    for (int a = 0; a < 4; a++) begin
      s = int'($urandom_range(1000)) - 500;
      h = int'($urandom_range(200, 1));
      d = (a % 2 == 0) ? 1 : -1;
      cfg(cw(a, 0, 0), s, h);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'(s));
      meas(off_th(a, s, h) - d, 1'b0);
      meas(on_th(a, s, h) - d, 1'b0);
      meas(on_th(a, s, h), 1'b1);
      meas(off_th(a, s, h) + d, 1'b1);
      meas(off_th(a, s, h), 1'b0);
    end
    // latch immediate: holds, front button and serial clear it
    cfg(cw(2, 1, 0), 100, 10);
    meas(100, 1'b1);
    meas(50, 1'b1);
    press(1'b1, 1'b0, 1'b0);
    chk1(out_drive, 1'b0);
    meas(100, 1'b1);
    apb(1'b1, 8'h14, 32'h1);
    repeat (4) @(posedge pclk);
    chk1(out_drive, 1'b0);
    // latch delayed: reset waits for trigger-off crossing
    apb(1'b1, 8'h00, cw(2, 2, 0));
    meas(50, 1'b0);
    meas(100, 1'b1);
    press(1'b0, 1'b1, 1'b0);
    chk1(out_drive, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0000000F);
    meas(95, 1'b1);
    meas(90, 1'b0);
    // reset with display only when input is shown
    apb(1'b1, 8'h00, cw(2, 1, 32'h100));
    rst_src_is_display <= 1'b1;
    meas(100, 1'b1);
    press(1'b0, 1'b0, 1'b1);
    chk1(out_drive, 1'b1);
    input_shown <= 1'b1;
    press(1'b0, 1'b0, 1'b1);
    chk1(out_drive, 1'b0);
    // on delay, reverted trigger, off delay
    apb(1'b1, 8'h00, cw(2, 0, 0));
    apb(1'b1, 8'h0C, 32'h3);
    meas(50, 1'b0);
    meas(100, 1'b0);
    repeat (40) @(posedge pclk);
    chk1(out_drive, 1'b1);
    meas(50, 1'b0);
    meas(100, 1'b0);
    meas(50, 1'b0);
    repeat (40) @(posedge pclk);
    chk1(out_drive, 1'b0);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h3);
    meas(100, 1'b1);
    meas(50, 1'b1);
    repeat (40) @(posedge pclk);
    chk1(out_drive, 1'b0);
    apb(1'b1, 8'h10, 32'h0);
    // colour follows each output change
    apb(1'b1, 8'h00, cw(2, 0, 32'h80));
    c = backlight_alt;
    meas(100, 1'b1);
    chk1(backlight_alt, ~c);
    meas(50, 1'b0);
    chk1(backlight_alt, c);
    // open probe forces burn-out level
    apb(1'b1, 8'h00, cw(2, 0, 32'h40));
    probe_open <= 1'b1;
    repeat (8) @(posedge pclk);
    chk1(out_drive, 1'b1);
    chk1(out_en, 1'b1);
    probe_open <= 1'b0;
    repeat (8) @(posedge pclk);
    chk1(out_drive, 1'b0);
    // disabled setpoint releases the card
    meas(100, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge pclk);
    chk({30'h0, out_en, relay_on}, 32'h0);
    // power cycle, then standby
    do_reset();
    chk1(out_drive, 1'b0);
    cfg(cw(2, 0, 32'h20), 100, 10);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h00000010);
    meas(100, 1'b0);
    meas(50, 1'b0);
    meas(100, 1'b1);
    final_report();
  end
endmodule
